/* File: hw/swt_counter.sv */
// 31-bit sleep counter advanced by slow-clock edge ticks
`timescale 1ns/100ps
module swt_counter (
    input  wire logic clk,
    input  wire logic rst_n,
    swt_slow_if.ctr   link
);
    logic [30:0] count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (link.count_reset) begin
            count_reg <= swt_pkg::SWT_COUNT_RELOAD;
        end else if (link.slow_tick) begin
            count_reg <= count_reg + 31'h0000_0001;
        end
    end

    assign link.count = count_reg;

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        link.count_reset |=> count_reg == swt_pkg::SWT_COUNT_RELOAD;
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter not reloaded with four");

    property p_advance;
        @(posedge clk) disable iff (!rst_n)
        (link.slow_tick && !link.count_reset)
            |=> count_reg == $past(count_reg) + 31'h0000_0001;
    endproperty
    a_advance: assert property (p_advance)
        else $error("counter did not advance on slow tick");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (!link.slow_tick && !link.count_reset) |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved without a slow tick");
endmodule

/* File: hw/swt_pkg.sv */
// Sleep wake-up timer constants and register map
package swt_pkg;
    // Special-function register addresses
    localparam logic [7:0] SWT_ADDR_IRQ_CTRL   = 8'ha1;
    localparam logic [7:0] SWT_ADDR_CONTROL    = 8'ha2;
    localparam logic [7:0] SWT_ADDR_CMP_LOW    = 8'ha3;
    localparam logic [7:0] SWT_ADDR_CMP_HIGH   = 8'ha4;
    localparam logic [7:0] SWT_ADDR_COUNT_LOW  = 8'ha5;
    localparam logic [7:0] SWT_ADDR_COUNT_HIGH = 8'ha6;
    // Field positions
    localparam int SWT_CTRL_RESET_BIT  = 2;
    localparam int SWT_IRQ_MASK_BIT    = 4;
    localparam int SWT_IRQ_FLAG_BIT    = 0;
    localparam int SWT_RES_STEP        = 5;
    // Reset values
    localparam logic [7:0]  SWT_CMP_HIGH_RST  = 8'h87;
    localparam logic [7:0]  SWT_CMP_LOW_RST   = 8'h6b;
    localparam logic [7:0]  SWT_COUNT_RST     = 8'h00;
    localparam logic [2:0]  SWT_CTRL_RSV_RST  = 3'h7;
    localparam logic [1:0]  SWT_RES_RST       = 2'h0;
    localparam logic [30:0] SWT_COUNT_RELOAD  = 31'h0000_0004;
    localparam logic [1:0]  SWT_SLEEP_ACTIVE  = 2'h0;
    // Power modes
    typedef enum logic [2:0] {
        SWT_PM_ACTIVE = 3'h0,
        SWT_PM_ZERO   = 3'h1,
        SWT_PM_ONE    = 3'h3,
        SWT_PM_TWO    = 3'h2,
        SWT_PM_THREE  = 3'h6
    } swt_pm_e;
endpackage

/* File: hw/swt_slow_if.sv */
// Signals shared between the system side and the slow-clock counter
`timescale 1ns/100ps
interface swt_slow_if;
    logic        slow_tick;
    logic        count_reset;
    logic [30:0] count;
    modport sys  (output slow_tick, output count_reset, input count);
    modport ctr  (input slow_tick, input count_reset, output count);
endinterface

/* File: hw/swt_timer.sv */
// Sleep wake-up timer top: SFR file, edge sync, compare and wake logic
//
// Behaviour
// - 31-bit counter, 16-bit slice by resolution
// - Counter advances on selected slow clock
// - Wake works only in modes 0-2
// - Wake event in modes 0-2 returns active
// - Interval is compare times 2^(5*res)
// - Low byte rate follows resolution
// - RC calibrates in active/mode 0 with crystal
// - Wake event sets wake event flag
// - Mask also sets CPU sleep flag
// - Flag with enable raises interrupt request
// - Interrupt blocked unless sleep mode 00
// - Low byte reads slice bits 7:0
// - Resolution picks bits 15:0 to 30:15
// - Reset bit reloads four, reads zero
// - Compare resets to 0x87 0x6b
`timescale 1ns/100ps
module swt_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       slow_clk_xtal,
    input  wire logic       slow_clk_rc,
    input  wire logic       slow_src_is_xtal,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [2:0] power_mode,
    input  wire logic [1:0] sleep_mode_select,
    input  wire logic       sleep_irq_enable,
    input  wire logic       cpu_sleep_irq_flag_clr,
    input  wire logic       hs_xtal_running,
    output logic            wake_to_active,
    output logic            cpu_sleep_irq_flag,
    output logic            sleep_irq_req,
    output logic            rc_cal_enable
);
    swt_slow_if link ();

    logic [2:0]  xtal_sync_reg;
    logic [2:0]  rc_sync_reg;
    logic [1:0]  src_sync_reg;
    logic [1:0]  sleep_resolution_select_reg;
    logic [2:0]  ctrl_rsv_reg;
    logic [7:0]  wake_compare_high_byte_reg;
    logic [7:0]  wake_compare_low_byte_reg;
    logic        wake_event_mask_reg;
    logic        irq_rsv_reg;
    logic        wake_event_flag_reg;
    logic        cpu_flag_reg;
    logic        match_prev_reg;
    logic [15:0] sleep_count_slice;
    logic [15:0] slice_snap_reg;
    logic        match;
    logic        wake_event;
    logic        sleep_modes;

    function automatic logic [15:0] swt_slice(input logic [30:0] c,
                                              input logic [1:0]  res);
        swt_slice = 16'(c >> (res * swt_pkg::SWT_RES_STEP));
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = sfr_wr && (sfr_addr == a);
    endfunction

    // Pin clocks pass two flops; the third stage is only for edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_sync_reg <= '0;
            rc_sync_reg   <= '0;
            src_sync_reg  <= '0;
        end else begin
            xtal_sync_reg <= {xtal_sync_reg[1:0], slow_clk_xtal};
            rc_sync_reg   <= {rc_sync_reg[1:0], slow_clk_rc};
            src_sync_reg  <= {src_sync_reg[0], slow_src_is_xtal};
        end
    end

    assign link.slow_tick = src_sync_reg[1]
        ? (xtal_sync_reg[1] && !xtal_sync_reg[2])
        : (rc_sync_reg[1] && !rc_sync_reg[2]);
    assign link.count_reset = wr_hit(swt_pkg::SWT_ADDR_CONTROL)
        && sfr_wdata[swt_pkg::SWT_CTRL_RESET_BIT];

    swt_counter u_counter (
        .clk   (clk),
        .rst_n (rst_n),
        .link  (link)
    );

    assign sleep_count_slice =
        swt_slice(link.count, sleep_resolution_select_reg);

    // Control register: resolution and reserved field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_resolution_select_reg <= swt_pkg::SWT_RES_RST;
            ctrl_rsv_reg                <= swt_pkg::SWT_CTRL_RSV_RST;
        end else if (wr_hit(swt_pkg::SWT_ADDR_CONTROL)) begin
            sleep_resolution_select_reg <= sfr_wdata[1:0];
            ctrl_rsv_reg                <= sfr_wdata[6:4];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_compare_high_byte_reg <= swt_pkg::SWT_CMP_HIGH_RST;
            wake_compare_low_byte_reg  <= swt_pkg::SWT_CMP_LOW_RST;
        end else begin
            if (wr_hit(swt_pkg::SWT_ADDR_CMP_HIGH))
                wake_compare_high_byte_reg <= sfr_wdata;
            if (wr_hit(swt_pkg::SWT_ADDR_CMP_LOW))
                wake_compare_low_byte_reg <= sfr_wdata;
        end
    end

    // equality match, one event per match entry
    assign match = sleep_count_slice ==
        {wake_compare_high_byte_reg, wake_compare_low_byte_reg};
    assign wake_event = match && !match_prev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            match_prev_reg <= 1'b0;
        else
            match_prev_reg <= match;
    end

    assign sleep_modes = (power_mode == swt_pkg::SWT_PM_ZERO)
        || (power_mode == swt_pkg::SWT_PM_ONE)
        || (power_mode == swt_pkg::SWT_PM_TWO);
    assign wake_to_active = wake_event && sleep_modes;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_event_flag_reg <= 1'b0;
            wake_event_mask_reg <= 1'b0;
            irq_rsv_reg         <= 1'b0;
        end else if (wake_event) begin
            wake_event_flag_reg <= 1'b1;
            if (wr_hit(swt_pkg::SWT_ADDR_IRQ_CTRL))
                wake_event_mask_reg <= sfr_wdata[swt_pkg::SWT_IRQ_MASK_BIT];
        end else if (wr_hit(swt_pkg::SWT_ADDR_IRQ_CTRL)) begin
            // Flag bits are write-zero-to-clear only
            wake_event_flag_reg <= wake_event_flag_reg
                & sfr_wdata[swt_pkg::SWT_IRQ_FLAG_BIT];
            irq_rsv_reg         <= irq_rsv_reg & sfr_wdata[1];
            wake_event_mask_reg <= sfr_wdata[swt_pkg::SWT_IRQ_MASK_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            cpu_flag_reg <= 1'b0;
        else if (wake_event && wake_event_mask_reg)
            cpu_flag_reg <= 1'b1;
        else if (cpu_sleep_irq_flag_clr)
            cpu_flag_reg <= 1'b0;
    end
    assign cpu_sleep_irq_flag = cpu_flag_reg;

    assign sleep_irq_req = cpu_flag_reg && sleep_irq_enable
        && (sleep_mode_select == swt_pkg::SWT_SLEEP_ACTIVE);

    assign rc_cal_enable = hs_xtal_running
        && ((power_mode == swt_pkg::SWT_PM_ACTIVE)
            || (power_mode == swt_pkg::SWT_PM_ZERO));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            slice_snap_reg <= {swt_pkg::SWT_COUNT_RST, swt_pkg::SWT_COUNT_RST};
        else
            slice_snap_reg <= sleep_count_slice;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                swt_pkg::SWT_ADDR_COUNT_LOW:  sfr_rdata <= slice_snap_reg[7:0];
                swt_pkg::SWT_ADDR_COUNT_HIGH:
                    sfr_rdata <= slice_snap_reg[15:8];
                swt_pkg::SWT_ADDR_CMP_HIGH:
                    sfr_rdata <= wake_compare_high_byte_reg;
                swt_pkg::SWT_ADDR_CMP_LOW:
                    sfr_rdata <= wake_compare_low_byte_reg;
                swt_pkg::SWT_ADDR_CONTROL:
                    sfr_rdata <= {1'b0, ctrl_rsv_reg, 2'b00,
                                  sleep_resolution_select_reg};
                swt_pkg::SWT_ADDR_IRQ_CTRL:
                    sfr_rdata <= {3'b000, wake_event_mask_reg, 2'b00,
                                  irq_rsv_reg, wake_event_flag_reg};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
        wake_event |=> wake_event_flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("wake flag not set by event");

    property p_cpu_flag;
        @(posedge clk) disable iff (!rst_n)
        (wake_event && wake_event_mask_reg) |=> cpu_flag_reg;
    endproperty
    a_cpu_flag: assert property (p_cpu_flag)
        else $error("cpu flag not set by masked event");

    property p_no_cpu_flag;
        @(posedge clk) disable iff (!rst_n)
        (!cpu_flag_reg && !(wake_event && wake_event_mask_reg))
            |=> !cpu_flag_reg;
    endproperty
    a_no_cpu_flag: assert property (p_no_cpu_flag)
        else $error("cpu flag set without masked event");

    property p_irq_block;
        @(posedge clk) disable iff (!rst_n)
        (sleep_mode_select != 2'h0) |-> !sleep_irq_req;
    endproperty
    a_irq_block: assert property (p_irq_block)
        else $error("interrupt not blocked in sleep mode");

    property p_irq_raise;
        @(posedge clk) disable iff (!rst_n)
        (cpu_flag_reg && sleep_irq_enable && sleep_mode_select == 2'h0)
            |-> sleep_irq_req;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("interrupt request missing");

    property p_wake_modes;
        @(posedge clk) disable iff (!rst_n)
        wake_to_active |-> (power_mode == 3'h1 || power_mode == 3'h3
                            || power_mode == 3'h2);
    endproperty
    a_wake_modes: assert property (p_wake_modes)
        else $error("wake outside modes 0 to 2");

    property p_wake_event;
        @(posedge clk) disable iff (!rst_n)
        (wake_event && power_mode == 3'h2) |-> wake_to_active;
    endproperty
    a_wake_event: assert property (p_wake_event)
        else $error("no wake on event in mode 2");

    property p_low_read;
        @(posedge clk) disable iff (!rst_n)
        (sfr_rd && sfr_addr == 8'ha5)
            |=> sfr_rdata == $past(slice_snap_reg[7:0]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low count byte read wrong");

    property p_cal;
        @(posedge clk) disable iff (!rst_n)
        (power_mode == 3'h3 || power_mode == 3'h2) |-> !rc_cal_enable;
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration running in mode 1 or 2");
endmodule

/* File: verification/test_sleep_wakeup_timer.sv */
// Self-checking bench for the sleep wake-up timer top
`timescale 1ns/100ps
module test_sleep_wakeup_timer;
    logic       clk;
    logic       rst_n;
    logic       xtal;
    logic       rc;
    logic       src_x;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [2:0] power_mode;
    logic [1:0] sel;
    logic       en;
    logic       fclr;
    logic       hs;
    logic       wake;
    logic       cflag;
    logic       req;
    logic       cal;
    int         mismatches;
    int         total_checks;
    int         cycles;
    int         wake_cnt;
    logic [7:0] exp_q [$];
    logic [2:0] pm_tab [5];

    swt_timer dut (.clk(clk), .rst_n(rst_n), .slow_clk_xtal(xtal),
        .slow_clk_rc(rc), .slow_src_is_xtal(src_x), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .power_mode(power_mode),
        .sleep_mode_select(sel), .sleep_irq_enable(en),
        .cpu_sleep_irq_flag_clr(fclr), .hs_xtal_running(hs),
        .wake_to_active(wake), .cpu_sleep_irq_flag(cflag),
        .sleep_irq_req(req), .rc_cal_enable(cal));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Hang guard, about twice the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles > 9000) begin
            mismatches++;
            give_verdict();
        end
        if (wake === 1'b1) begin
            wake_cnt++;
        end
    end

    // Read results land on the taking edge and are checked at the next negedge
    always @(posedge clk) begin
        if (sfr_rd === 1'b1) begin
            @(negedge clk);
            if (exp_q.size() == 0) begin
                chk(sfr_rdata, 8'hxx);
            end else begin
                chk(sfr_rdata, exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge clk);
        sfr_wr = 1'b0;
        // Gap cycle so a following read sees the settled snapshot
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
    endtask

    // Slow edges kept well under clk/4
    task automatic edges(input int n, input logic use_rc);
        for (int j = 0; j < n; j++) begin
            if (use_rc) rc = 1'b1; else xtal = 1'b1;
            repeat (4) @(negedge clk);
            if (use_rc) rc = 1'b0; else xtal = 1'b0;
            repeat (4) @(negedge clk);
        end
    endtask

    initial begin
        int         k;
        logic       msk;
        logic [7:0] d;
        logic [30:0] cnt;
        {rst_n, xtal, rc, sfr_wr, sfr_rd, fclr, hs} = '0;
        {sfr_addr, sfr_wdata, sel} = '0;
        {src_x, en} = 2'b11;
        power_mode = swt_pkg::SWT_PM_ACTIVE;
        pm_tab = '{swt_pkg::SWT_PM_ACTIVE, swt_pkg::SWT_PM_ZERO,
                   swt_pkg::SWT_PM_ONE, swt_pkg::SWT_PM_TWO,
                   swt_pkg::SWT_PM_THREE};
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        wake_cnt = 0;
        void'($urandom(32'h5993));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(swt_pkg::SWT_ADDR_CMP_LOW, 8'h6b);
        rd(swt_pkg::SWT_ADDR_CMP_HIGH, 8'h87);
        rd(swt_pkg::SWT_ADDR_COUNT_LOW, 8'h00);
        rd(swt_pkg::SWT_ADDR_CONTROL, 8'h70);
        rd(swt_pkg::SWT_ADDR_IRQ_CTRL, 8'h00);
        rd(8'h9c, 8'h00);
        d = 8'($urandom());
        wr(swt_pkg::SWT_ADDR_CMP_LOW, d);
        wr(swt_pkg::SWT_ADDR_COUNT_LOW, 8'hff);
        rd(swt_pkg::SWT_ADDR_CMP_LOW, d);
        rd(swt_pkg::SWT_ADDR_COUNT_LOW, 8'h00);
        wr(swt_pkg::SWT_ADDR_CONTROL, 8'h05);
        rd(swt_pkg::SWT_ADDR_CONTROL, 8'h01);
        // Reload to four, then 60 edges reaches 64
        wr(swt_pkg::SWT_ADDR_CONTROL, 8'h04);
        edges(60, 1'b0);
        cnt = 31'd64;
        for (int r = 0; r < 4; r++) begin
            wr(swt_pkg::SWT_ADDR_CONTROL, 8'(r));
            d = 8'(cnt >> (5 * r));
            rd(swt_pkg::SWT_ADDR_COUNT_LOW, d);
            d = 8'(cnt >> (5 * r + 8));
            rd(swt_pkg::SWT_ADDR_COUNT_HIGH, d);
        end
        // Switch to the RC source; crystal edges must not count
        src_x = 1'b0;
        repeat (4) @(negedge clk);
        edges(3, 1'b0);
        edges(5, 1'b1);
        wr(swt_pkg::SWT_ADDR_CONTROL, 8'h00);
        rd(swt_pkg::SWT_ADDR_COUNT_LOW, 8'h45);
        src_x = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            sel = (i == 2) ? 2'h2 : 2'h0;
            msk = (i != 3);
            wr(swt_pkg::SWT_ADDR_IRQ_CTRL, {3'h0, msk, 4'h0});
            fclr = 1'b1;
            @(negedge clk);
            fclr = 1'b0;
            wr(swt_pkg::SWT_ADDR_CONTROL, 8'h04);
            edges(2, 1'b0);
            // Mode two needs a long sleep before its event
            k = 1 + int'($urandom() % 8) + ((i == 3) ? 384 : 0);
            wr(swt_pkg::SWT_ADDR_CMP_HIGH, 8'((6 + k) >> 8));
            wr(swt_pkg::SWT_ADDR_CMP_LOW, 8'(6 + k));
            power_mode = pm_tab[i];
            wake_cnt = 0;
            edges(k + 2, 1'b0);
            chk(8'(wake_cnt), 8'(i > 0 && i < 4));
            if (i > 0 && i < 4) begin
                rd(swt_pkg::SWT_ADDR_IRQ_CTRL, {3'h0, msk, 4'h1});
                chk(8'(cflag), 8'(msk));
                chk(8'(req), 8'(msk && i == 1));
            end
            if (i == 1) begin
                en = 1'b0;
                #1 chk(8'(req), 8'h00);
                en = 1'b1;
                fclr = 1'b1;
                @(negedge clk);
                fclr = 1'b0;
                @(negedge clk);
                chk(8'(cflag), 8'h00);
            end
        end
        // Calibration only with fast crystal in active or mode zero
        for (int i = 0; i < 10; i++) begin
            power_mode = pm_tab[i % 5];
            hs = (i >= 5);
            #1 chk(8'(cal), 8'(hs && (i % 5) < 2));
            @(negedge clk);
        end
        repeat (4) @(negedge clk);
        if (exp_q.size() != 0) begin
            mismatches++;
        end
        give_verdict();
    end
endmodule
